// *** hdl/ccr_pkg.sv ***
// Package with the register map, reset values, field positions and timing constants.
package ccr_pkg;

  localparam logic [7:0] ADDR_THERMAL = 8'h40;
  localparam logic [7:0] ADDR_CUR_ONE = 8'h41;
  localparam logic [7:0] ADDR_CUR_TWO = 8'h42;
  localparam logic [7:0] ADDR_CONTROL = 8'h43;
  localparam logic [7:0] ADDR_VOLTAGE = 8'h44;
  localparam logic [7:0] ADDR_PRE_DONE = 8'h45;
  localparam logic [7:0] ADDR_TIMERS = 8'h46;
  localparam logic [7:0] ADDR_STEP = 8'h47;
  localparam logic [7:0] ADDR_STATUS = 8'h4e;
  localparam logic [7:0] ADDR_SYS_MIN = 8'h4f;

  localparam int NUM_REGS = 9;
  localparam logic [3:0] IDX_NONE = 4'hf;
  localparam logic [3:0] IDX_SYS_MIN = 4'h8;

  localparam logic [NUM_REGS-1:0][7:0] RESET_VALUES = {
    8'h00, 8'h52, 8'h00, 8'h3a, 8'h8f, 8'h61, 8'h2d, 8'h43, 8'h0f};
  localparam logic [NUM_REGS-1:0][7:0] WRITE_MASKS = {
    8'h0f, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'he7, 8'h7f, 8'h7f, 8'h0f};

  localparam int BIT_CHG_EN = 7;
  localparam int BIT_AUTO_STOP = 6;
  localparam int BIT_AUTO_RESTART = 5;
  localparam int BIT_ROOM_ONLY = 2;
  localparam int BIT_TMO_LIMIT = 1;
  localparam int BIT_CC1_EN = 0;

  localparam logic [15:0] SYS_MIN_BASE_MV = 16'd3000;
  localparam logic [15:0] SYS_MIN_STEP_MV = 16'd100;
  localparam logic [7:0] THERM_BASE_C = 8'd40;
  localparam logic [7:0] THERM_STEP_C = 8'd5;
  localparam logic [15:0] VREG_BASE_MV = 16'd4050;
  localparam logic [15:0] VREG_STEP_MV = 16'd10;
  localparam logic [15:0] VREG_CAP_MV = 16'd4600;
  localparam logic [15:0] RECHG_STEP_MV = 16'd50;
  localparam logic [15:0] VPRE_BASE_MV = 16'd2700;
  localparam logic [15:0] VPRE_STEP_MV = 16'd100;
  localparam logic [15:0] STEP_RISE_BASE_MV = 16'd3800;
  localparam logic [15:0] STEP_RISE_STEP_MV = 16'd50;
  localparam logic [15:0] STEP_HYS_STEP_MV = 16'd100;
  localparam logic [15:0] STEP_HYS_MAX_MV = 16'd600;

  localparam logic [6:0] CUR_KNEE_ONE = 7'h3c;
  localparam logic [6:0] CUR_KNEE_TWO = 7'h4f;
  localparam logic [6:0] CUR_KNEE_THREE = 7'h53;
  localparam logic [7:0] CUR_BASE_MA = 8'd5;
  localparam logic [7:0] CUR_MID_MA = 8'd65;
  localparam logic [7:0] CUR_HIGH_MA = 8'd160;
  localparam logic [7:0] CUR_MAX_MA = 8'd200;
  localparam logic [17:0] UA_PER_MA = 18'd1000;

  localparam logic [3:0][8:0] PRE_RATIO_PERMILLE = {9'd300, 9'd200, 9'd100, 9'd50};
  localparam logic [3:0][8:0] DONE_RATIO_PERMILLE = {9'd200, 9'd100, 9'd50, 9'd25};

  localparam logic [9:0] PRE_TIMER_BASE_MIN = 10'd30;
  localparam logic [9:0] MAINT_TIMER_BASE_MIN = 10'd15;
  localparam logic [9:0] SAFETY_TIMER_BASE_MIN = 10'd75;

  localparam longint CLK_HZ = 40000000;
  localparam longint SEC_PER_MIN = 60;
  localparam longint CYC_PER_MIN = CLK_HZ * SEC_PER_MIN;

  typedef enum logic [6:0] {
    CCR_OFF = 7'h01,
    CCR_PRE = 7'h02,
    CCR_CC1 = 7'h04,
    CCR_CC2 = 7'h08,
    CCR_MAINT = 7'h10,
    CCR_DONE = 7'h20,
    CCR_FAULT = 7'h40
  } ccr_state_t;

endpackage

// *** hdl/ccr_regs.sv ***
// Charger configuration register bank with decoded setpoints and the charge sequencer.
//
// Contract
// R1: System minimum voltage code maps to 3.0 V plus 0.1 V per step.
// R2: Thermal shutdown code maps to 40 C plus 5 C per step.
// R3: Zone-one current is piecewise 1, 5, 10 mA steps, saturating at 200 mA.
// R4: Zone-two current uses the same piecewise mapping, saturating at 200 mA.
// R5: Maintain charge moves to done only while auto-stop is set.
// R6: With auto-restart, done restarts below recharge threshold; otherwise stays done.
// R7: Room-only restricts the first current phase to room temperature zone.
// R8: First phase times out to second phase unless the timeout-limit bit is set.
// R9: First phase enable clear skips the first current phase.
// R10: Recharge threshold is regulation voltage minus 50, 100, 150 or 200 mV.
// R11: Regulation voltage is code times 10 mV plus 4.05 V, capped at 4.6 V.
// R12: Software should keep the regulation code at or below 0x38.
// R13: Pre-charge threshold is 2.70 V plus 0.1 V per step.
// R14: Pre-charge current is 0.05, 0.10, 0.20 or 0.30 of fast current.
// R15: Done threshold is 0.025, 0.05, 0.10 or 0.20 of zone-two current.
// R16: Maintain timer selects 0, 15, 30 or 60 minutes.
// R17: Pre-charge and first-phase timers select 30, 60, 120 or 240 minutes.
// R18: Safety timer of 75 to 600 minutes runs through pre-charge to constant voltage.
// R19: The sequencer runs only while the charger enable bit is set.
// R20: Registers read back their last written value with unused bits zero.
//
// Our own choice: the plain strobed port.
module ccr_regs #(
  parameter logic [31:0] CYC_PER_MIN = 32'(ccr_pkg::CYC_PER_MIN)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] vbat_mv,
  input wire logic [17:0] ibat_ua,
  input wire logic thm_room,
  input wire logic [7:0] die_temp_c,
  output logic [15:0] min_system_mv,
  output logic [7:0] thermal_shutdown_c,
  output logic [15:0] regulation_mv,
  output logic [15:0] recharge_mv,
  output logic [15:0] precharge_mv,
  output logic [17:0] precharge_ua,
  output logic [17:0] done_ua,
  output logic [15:0] step_rise_mv,
  output logic [15:0] step_hys_mv,
  output logic [17:0] charge_current_ua,
  output logic [6:0] charger_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and helper functions.

  typedef struct packed {
    logic [ccr_pkg::NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    ccr_pkg::ccr_state_t st;
    logic [31:0] tick_cnt;
    logic [9:0] phase_min;
    logic [9:0] safe_min;
    logic [15:0] sys_min_mv;
    logic [7:0] therm_c;
    logic [15:0] vreg_mv;
    logic [15:0] vrechg_mv;
    logic [15:0] vpre_mv;
    logic [17:0] ipre_ua;
    logic [17:0] idone_ua;
    logic [15:0] rise_mv;
    logic [15:0] hys_mv;
    logic [17:0] ichg_ua;
  } ccr_core_t;

  ccr_core_t q_r;
  ccr_core_t q_nxt;

  function automatic logic [3:0] addr_index(input logic [7:0] a);
    if (a >= ccr_pkg::ADDR_THERMAL && a <= ccr_pkg::ADDR_STEP)
      return 4'(a - ccr_pkg::ADDR_THERMAL);
    else if (a == ccr_pkg::ADDR_SYS_MIN)
      return ccr_pkg::IDX_SYS_MIN;
    else
      return ccr_pkg::IDX_NONE;
  endfunction

  // Fast-charge code to milliamps; codes above the last knee saturate.
  function automatic logic [7:0] fast_ma(input logic [6:0] c);
    if (c <= ccr_pkg::CUR_KNEE_ONE)
      return 8'(ccr_pkg::CUR_BASE_MA + 8'(c));
    else if (c <= ccr_pkg::CUR_KNEE_TWO)
      return 8'(ccr_pkg::CUR_MID_MA + 8'd5 * 8'(c - ccr_pkg::CUR_KNEE_ONE));
    else if (c <= ccr_pkg::CUR_KNEE_THREE)
      return 8'(ccr_pkg::CUR_HIGH_MA + 8'd10 * 8'(c - ccr_pkg::CUR_KNEE_TWO));
    else
      return ccr_pkg::CUR_MAX_MA;
  endfunction

  function automatic logic [9:0] timer_min(input logic [1:0] sel, input logic [9:0] base);
    return 10'(base << sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic [3:0] idx;
  logic [7:0] ctl;
  logic [7:0] ma_one;
  logic [7:0] ma_two;
  logic minute;
  logic cc1_ok;
  logic safety_out;
  logic [9:0] maint_lim;
  ccr_pkg::ccr_state_t go;

  always_comb
  begin
    q_nxt = q_r;
    idx = addr_index(reg_addr);
    ctl = q_r.regs[3];
    ma_one = fast_ma(q_r.regs[1][6:0]); // R3
    ma_two = fast_ma(q_r.regs[2][6:0]); // R4
    q_nxt.rdata = 8'h00;
    if (reg_wr && idx != ccr_pkg::IDX_NONE)
    begin
      q_nxt.regs[idx] = reg_wdata & ccr_pkg::WRITE_MASKS[idx]; // R20
    end
    if (reg_rd)
    begin
      if (idx != ccr_pkg::IDX_NONE)
        q_nxt.rdata = q_r.regs[idx]; // R20
      else if (reg_addr == ccr_pkg::ADDR_STATUS)
        q_nxt.rdata = {1'b0, q_r.st};
    end

    q_nxt.sys_min_mv = 16'(ccr_pkg::SYS_MIN_BASE_MV
      + ccr_pkg::SYS_MIN_STEP_MV * 16'(q_r.regs[8][3:0])); // R1
    q_nxt.therm_c = 8'(ccr_pkg::THERM_BASE_C
      + ccr_pkg::THERM_STEP_C * 8'(q_r.regs[0][3:0])); // R2
    q_nxt.vreg_mv = 16'(ccr_pkg::VREG_BASE_MV
      + ccr_pkg::VREG_STEP_MV * 16'(q_r.regs[4][5:0])); // R11
    if (q_nxt.vreg_mv > ccr_pkg::VREG_CAP_MV)
      q_nxt.vreg_mv = ccr_pkg::VREG_CAP_MV; // R11
    // The recharge threshold follows the capped regulation value of this same update.
    q_nxt.vrechg_mv = 16'(q_nxt.vreg_mv
      - ccr_pkg::RECHG_STEP_MV * 16'({1'b0, q_r.regs[4][7:6]} + 3'd1)); // R10
    q_nxt.vpre_mv = 16'(ccr_pkg::VPRE_BASE_MV
      + ccr_pkg::VPRE_STEP_MV * 16'(q_r.regs[5][6:4])); // R13
    q_nxt.ipre_ua = 18'(18'(ma_two)
      * 18'(ccr_pkg::PRE_RATIO_PERMILLE[q_r.regs[5][3:2]])); // R14
    q_nxt.idone_ua = 18'(18'(ma_two)
      * 18'(ccr_pkg::DONE_RATIO_PERMILLE[q_r.regs[5][1:0]])); // R15
    q_nxt.rise_mv = 16'(ccr_pkg::STEP_RISE_BASE_MV
      + ccr_pkg::STEP_RISE_STEP_MV * 16'(q_r.regs[7][3:0]));
    if (q_r.regs[7][6:4] >= 3'd5)
      q_nxt.hys_mv = ccr_pkg::STEP_HYS_MAX_MV;
    else
      q_nxt.hys_mv = 16'(ccr_pkg::STEP_HYS_STEP_MV * 16'({1'b0, q_r.regs[7][6:4]} + 4'd1));

    // Minute prescaler shared by all charge timers.
    minute = (q_r.tick_cnt == 32'(CYC_PER_MIN - 32'd1));
    q_nxt.tick_cnt = minute ? 32'h0000_0000 : 32'(q_r.tick_cnt + 32'd1);
    if (minute && q_r.phase_min != 10'h3ff)
      q_nxt.phase_min = 10'(q_r.phase_min + 10'd1);
    if (minute && q_r.safe_min != 10'h3ff &&
        (q_r.st == ccr_pkg::CCR_PRE || q_r.st == ccr_pkg::CCR_CC1 ||
         q_r.st == ccr_pkg::CCR_CC2 || q_r.st == ccr_pkg::CCR_MAINT))
      q_nxt.safe_min = 10'(q_r.safe_min + 10'd1); // R18

    cc1_ok = ctl[ccr_pkg::BIT_CC1_EN] // R9
      && (!ctl[ccr_pkg::BIT_ROOM_ONLY] || thm_room); // R7
    safety_out = q_r.safe_min
      >= timer_min(q_r.regs[6][1:0], ccr_pkg::SAFETY_TIMER_BASE_MIN); // R18
    if (q_r.regs[6][7:6] == 2'd0)
      maint_lim = 10'd0; // R16
    else
      maint_lim = timer_min(2'(q_r.regs[6][7:6] - 2'd1), ccr_pkg::MAINT_TIMER_BASE_MIN); // R16

    go = q_r.st;
    case (q_r.st)
      ccr_pkg::CCR_OFF:
        go = ccr_pkg::CCR_PRE;
      ccr_pkg::CCR_PRE:
        if (vbat_mv >= q_r.vpre_mv)
          go = cc1_ok ? ccr_pkg::CCR_CC1 : ccr_pkg::CCR_CC2; // R9
        else if (q_r.phase_min >= timer_min(q_r.regs[6][5:4], ccr_pkg::PRE_TIMER_BASE_MIN))
          go = ccr_pkg::CCR_FAULT; // R17
      ccr_pkg::CCR_CC1:
        if (vbat_mv >= q_r.vreg_mv)
          go = ccr_pkg::CCR_MAINT;
        else if (!cc1_ok)
          go = ccr_pkg::CCR_CC2; // R7
        else if (!ctl[ccr_pkg::BIT_TMO_LIMIT] && q_r.phase_min
                 >= timer_min(q_r.regs[6][3:2], ccr_pkg::PRE_TIMER_BASE_MIN))
          go = ccr_pkg::CCR_CC2; // R8
        else if (vbat_mv >= q_r.rise_mv)
          go = ccr_pkg::CCR_CC2;
      ccr_pkg::CCR_CC2:
        if (vbat_mv >= q_r.vreg_mv)
          go = ccr_pkg::CCR_MAINT;
      ccr_pkg::CCR_MAINT:
        if (ctl[ccr_pkg::BIT_AUTO_STOP] && ibat_ua < q_r.idone_ua
            && q_r.phase_min >= maint_lim)
          go = ccr_pkg::CCR_DONE; // R5
      ccr_pkg::CCR_DONE:
        if (ctl[ccr_pkg::BIT_AUTO_RESTART] && vbat_mv < q_r.vrechg_mv)
          go = ccr_pkg::CCR_PRE; // R6
      ccr_pkg::CCR_FAULT:
        go = ccr_pkg::CCR_FAULT;
      default:
        go = ccr_pkg::CCR_OFF;
    endcase
    // A safety expiry outranks every ordinary phase change except moves into or out of done and moves out of off.
    if (safety_out && go != ccr_pkg::CCR_DONE && q_r.st != ccr_pkg::CCR_DONE
        && q_r.st != ccr_pkg::CCR_OFF)
      go = ccr_pkg::CCR_FAULT; // R18
    if (!ctl[ccr_pkg::BIT_CHG_EN])
      go = ccr_pkg::CCR_OFF; // R19
    q_nxt.st = go;
    if (go != q_r.st)
    begin
      q_nxt.phase_min = 10'd0;
      q_nxt.tick_cnt = 32'h0000_0000;
      if (go == ccr_pkg::CCR_PRE || go == ccr_pkg::CCR_OFF)
        q_nxt.safe_min = 10'd0;
    end

    case (q_r.st)
      ccr_pkg::CCR_PRE:
        q_nxt.ichg_ua = q_r.ipre_ua; // R14
      ccr_pkg::CCR_CC1:
        q_nxt.ichg_ua = 18'(18'(ma_one) * ccr_pkg::UA_PER_MA); // R3
      ccr_pkg::CCR_CC2, ccr_pkg::CCR_MAINT:
        q_nxt.ichg_ua = 18'(18'(ma_two) * ccr_pkg::UA_PER_MA); // R4
      default:
        q_nxt.ichg_ua = 18'd0;
    endcase
    // At or over the thermal limit the current is held off but the phase is kept.
    if (die_temp_c >= q_r.therm_c)
      q_nxt.ichg_ua = 18'd0; // R2
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_r <= '0;
      q_r.regs <= ccr_pkg::RESET_VALUES;
      q_r.st <= ccr_pkg::CCR_OFF;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign min_system_mv = q_r.sys_min_mv;
  assign thermal_shutdown_c = q_r.therm_c;
  assign regulation_mv = q_r.vreg_mv;
  assign recharge_mv = q_r.vrechg_mv;
  assign precharge_mv = q_r.vpre_mv;
  assign precharge_ua = q_r.ipre_ua;
  assign done_ua = q_r.idone_ua;
  assign step_rise_mv = q_r.rise_mv;
  assign step_hys_mv = q_r.hys_mv;
  assign charge_current_ua = q_r.ichg_ua;
  assign charger_state = q_r.st;

endmodule

// *** sim/ccr_regs_chk.sv ***
// Port assertions for the charger configuration register bank.
module ccr_regs_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] min_system_mv,
  input wire logic [7:0] thermal_shutdown_c,
  input wire logic [15:0] regulation_mv,
  input wire logic [15:0] recharge_mv,
  input wire logic [15:0] precharge_mv,
  input wire logic [6:0] charger_state
);
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded outputs are only valid from the first edge after release, so wait.
  logic [1:0] age_r;
  logic live;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  assign live = age_r == 2'h3;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_ctl_wr(b);
    reg_wr && reg_addr == 8'h43 && reg_wdata[7] == b;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (live && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  a_ctl_gap_zero: assert property (reg_rd && reg_addr == 8'h43 |=> reg_rdata[4:3] == 2'h0)
    else $error("unused control bits read nonzero");
  a_therm_step: assert property (live |-> thermal_shutdown_c >= 8'd40 &&
    thermal_shutdown_c <= 8'd115 && (thermal_shutdown_c - 8'd40) % 5 == 0)
    else $error("thermal limit off the 5 degree grid");
  a_min_system_voltage_step: assert property (live |-> min_system_mv >= 16'd3000 &&
    min_system_mv <= 16'd4500 && min_system_mv % 100 == 0)
    else $error("minimum system voltage off grid");
  a_vreg_cap: assert property (live |-> regulation_mv >= 16'd4050 &&
    regulation_mv <= 16'd4600 && (regulation_mv - 16'd4050) % 10 == 0)
    else $error("regulation voltage off grid or above cap");
  a_recharge_gap: assert property (live |-> (regulation_mv - recharge_mv)
    inside {16'd50, 16'd100, 16'd150, 16'd200})
    else $error("recharge offset not a legal step");
  a_pre_step: assert property (live |-> precharge_mv >= 16'd2700 &&
    precharge_mv <= 16'd3400 && precharge_mv % 100 == 0)
    else $error("precharge threshold off grid");
  a_disable_off: assert property (s_ctl_wr(1'b0) |-> ##2 charger_state == 7'h01)
    else $error("sequencer not off after disable");
  a_enable_start: assert property ((s_ctl_wr(1'b1) ##0 charger_state == 7'h01)
    |-> ##2 charger_state == 7'h02)
    else $error("sequencer did not start precharge");
  a_state_onehot: assert property ($onehot(charger_state))
    else $error("sequencer state not one-hot");
endmodule
bind ccr_regs ccr_regs_chk ccr_regs_chk_inst (.*);

// *** sim/tb_top.sv ***
// Self-checking bench for the charger configuration register bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] vbat_mv = 16'd3000;
  logic [17:0] ibat_ua = 18'h00000;
  logic thm_room = 1'b1;
  logic [7:0] die_temp_c = 8'h19;
  logic [7:0] reg_rdata, thermal_shutdown_c;
  logic [15:0] min_system_mv, regulation_mv, recharge_mv, precharge_mv, step_rise_mv, step_hys_mv;
  logic [17:0] precharge_ua, done_ua, charge_current_ua;
  logic [6:0] charger_state;
  int failures = 0;
  int total_checks = 0;
  logic [7:0] mdl [9] = '{8'h0f, 8'h43, 8'h2d, 8'h61, 8'h8f, 8'h3a, 8'h00, 8'h52, 8'h00};
  logic [7:0] msk [9] = '{8'h0f, 8'h7f, 8'h7f, 8'he7, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'h0f};
  int pr [4] = '{50, 100, 200, 300};
  int dn [4] = '{25, 50, 100, 200};
  // A short minute keeps every sequencer timer well inside the run.
  ccr_regs #(.CYC_PER_MIN(32'h4)) ccr_regs_inst (.*);
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int ix(input logic [7:0] a);
    return a == 8'h4f ? 8 : int'(a) - 'h40;
  endfunction
  function automatic int cur_ma(input int c);
    if (c <= 'h3c) return 5 + c;
    if (c <= 'h4f) return 65 + 5 * (c - 'h3c);
    if (c <= 'h53) return 160 + 10 * (c - 'h4f);
    return 200;
  endfunction
  task automatic chk(input logic [17:0] got, input int exp, input string what);
    total_checks++;
    if (got !== 18'(exp))
    begin
      failures++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 8'h4f || (a >= 8'h40 && a <= 8'h47)) mdl[ix(a)] = d & msk[ix(a)];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, (a == 8'h4f || (a >= 8'h40 && a <= 8'h47)) ? mdl[ix(a)] : 0, "read");
  endtask
  task automatic dec();
    int r, c2;
    repeat (2) @(posedge clk_sys);
    #1;
    r = 4050 + 10 * (mdl[4] & 'h3f);
    r = r > 4600 ? 4600 : r;
    c2 = cur_ma(mdl[2] & 'h7f);
    chk(min_system_mv, 3000 + 100 * (mdl[8] & 'hf), "min_system_voltage");
    chk(thermal_shutdown_c, 40 + 5 * (mdl[0] & 'hf), "thermal");
    chk(regulation_mv, r, "regulation");
    chk(recharge_mv, r - 50 * ((mdl[4] >> 6) + 1), "recharge");
    chk(precharge_mv, 2700 + 100 * ((mdl[5] >> 4) & 7), "pre volt");
    chk(precharge_ua, c2 * pr[(mdl[5] >> 2) & 3], "pre cur");
    chk(done_ua, c2 * dn[mdl[5] & 3], "done cur");
  endtask
  task automatic wait_st(input logic [6:0] s);
    for (int n = 0; n < 20 && charger_state !== s; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk(charger_state, s, "state");
  endtask
  task automatic end_of_test();
    $display("counts: %0d checks, %0d failures", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200us;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    logic [7:0] a, d;
    static logic [7:0] cur [8] = '{8'h00, 8'h3c, 8'h3d, 8'h4f, 8'h50, 8'h53, 8'h54, 8'h7f};
    static logic [7:0] ctl [3] = '{8'h81, 8'h85, 8'h80};
    static logic room [3] = '{1'b1, 1'b0, 1'b1};
    static logic [6:0] exp_st [3] = '{7'h04, 7'h08, 7'h08};
    void'($urandom(768));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(i == 8 ? 8'h4f : 8'(8'h40 + i));
    rd(8'h50);
    dec();
    $display("test reset values done");
    repeat (16)
    begin
      a = 8'($urandom_range(0, 8));
      a = a == 8'h8 ? 8'h4f : 8'h40 + a;
      // Random control writes keep the sequencer off so its test starts clean.
      d = 8'($urandom) & (a == 8'h43 ? 8'h7f : 8'hff);
      wr(a, d);
      rd(a);
      dec();
    end
    foreach (cur[i])
    begin
      wr(8'h42, cur[i]);
      dec();
    end
    wr(8'h44, 8'h38);
    dec();
    $display("test random and boundary codes done");
    // Longest safety limit so that the full charge walk below never faults.
    wr(8'h46, 8'h03);
    wr(8'h45, 8'h00);
    wr(8'h41, 8'h3d);
    wr(8'h40, 8'h0f);
    foreach (ctl[i])
    begin
      wr(8'h43, 8'h00);
      wait_st(7'h01);
      thm_room <= room[i];
      wr(8'h43, ctl[i]);
      wait_st(exp_st[i]);
    end
    wr(8'h43, 8'h00);
    wait_st(7'h01);
    thm_room <= 1'b1;
    wr(8'h43, 8'h81);
    wait_st(7'h04);
    @(posedge clk_sys);
    #1;
    chk(charge_current_ua, 70000, "cc1 current");
    $display("test sequencer entry done");
    // The first phase timer is thirty short minutes of four cycles each.
    repeat (110) @(posedge clk_sys);
    wait_st(7'h08);
    @(posedge clk_sys);
    #1;
    chk(charge_current_ua, cur_ma(mdl[2] & 'h7f) * 1000, "cc2 current");
    @(posedge clk_sys);
    vbat_mv <= 16'd4600;
    ibat_ua <= 18'h00000;
    wait_st(7'h10);
    repeat (8) @(posedge clk_sys);
    #1;
    chk(charger_state, 'h10, "no auto-stop");
    wr(8'h43, 8'hc1);
    wait_st(7'h20);
    @(posedge clk_sys);
    vbat_mv <= 16'd3000;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(charger_state, 'h20, "no auto-restart");
    wr(8'h43, 8'he1);
    wait_st(7'h02);
    $display("test charge walk done");
    end_of_test();
  end
endmodule
